// >>> common/crd_pkg.sv
// Purpose: Shared constants and types for the CCD readout windowing block.
// Assumes: 8-bit converter samples, 1300 x 1030 sensor array, 200 MHz ref_clk.
// Notes:   Times are kept in ns; cycle counts derive from the clock period.
package crd_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam logic [10:0] SENSOR_COLS = 11'd1300; // Full array width
  localparam logic [10:0] SENSOR_ROWS = 11'd1030; // Full array height
  localparam logic [10:0] BIN_COLS    = 11'd650;  // Width after pairing columns
  localparam logic [10:0] BIN_ROWS    = 11'd515;  // Height after pairing rows
  localparam int          LINE_DEPTH  = 1300;     // Line memory entries
  localparam int          PIX_W       = 8;        // Sample width
  localparam int          SUM_W       = 10;       // Room for four summed samples
  // ----------------------------------------------------------------
  // Gain
  // ----------------------------------------------------------------
  localparam logic [8:0]  GAIN_DEFAULT  = 9'h065; // Nominal 14 dB point
  localparam logic [8:0]  GAIN_TOP      = 9'h13f; // Highest code that adds gain
  localparam logic [15:0] GAIN_BASE_MDB = 16'h1194; // 4.5 dB at code zero, in mdB
  localparam int          GAIN_SLOPE_Q8 = 24075;  // 94.04 mdB per code, 8 fraction bits
  // ----------------------------------------------------------------
  // Format and mode selectors
  // ----------------------------------------------------------------
  localparam logic [2:0] FORMAT_SCALABLE = 3'h7;
  localparam logic [2:0] SEL_ROI         = 3'h0;
  localparam logic [2:0] SEL_HBIN        = 3'h1;
  localparam logic [2:0] SEL_VBIN        = 3'h2;
  localparam logic [2:0] SEL_FBIN        = 3'h3;
  // ----------------------------------------------------------------
  // Frame time
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int FT_FIXED_NS   = 43000;
  localparam int FT_SKIP_NS    = 5440;
  localparam int FT_ROW_NS     = 80050;
  localparam int FT_TAIL_NS    = 100;
  localparam int FT_BIN_NS     = 43687200; // 22.89 frames per second
  localparam logic [10:0] FT_ROW_REF = 11'd1029;
  localparam int FT_FIXED_CYC  = (FT_FIXED_NS + FT_TAIL_NS) / CLK_PERIOD_NS;
  localparam int FT_SKIP_CYC   = FT_SKIP_NS / CLK_PERIOD_NS;
  localparam int FT_ROW_CYC    = FT_ROW_NS / CLK_PERIOD_NS;
  localparam int FT_BIN_CYC    = FT_BIN_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_ROI = 3'h1, MODE_HBIN = 3'h2,
    MODE_VBIN = 3'h3, MODE_FBIN = 3'h4
  } crd_mode_t;
  typedef enum logic [1:0] {ST_WAIT = 2'b00, ST_FRAME = 2'b01} crd_state_t;
  typedef struct packed {
    logic             sof;  // First pixel of a frame
    logic [PIX_W-1:0] data; // Converter sample
  } crd_pix_in_t;
  typedef struct packed {
    logic             sof;  // First pixel of the output frame
    logic             eol;  // Last pixel of an output line
    logic [SUM_W-1:0] data; // Pixel or binned sum
  } crd_pix_out_t;
  typedef struct packed {
    logic [10:0] left;
    logic [10:0] top;
    logic [10:0] width;
    logic [10:0] height;
  } crd_roi_t;
endpackage

// >>> verilog/crd_line_mem.sv
// Purpose: One-line store used to pair rows for vertical binning.
// Assumes: Single clock, one write and one read port.
// Notes:   Read data is registered, one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module crd_line_mem
  import crd_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             wrEn,
  input  wire logic [10:0]      wrAddr,
  input  wire logic [SUM_W-1:0] wrData,
  input  wire logic [10:0]      rdAddr,
  output logic [SUM_W-1:0]      rdData
);
  // Storage array
  logic [SUM_W-1:0] mem [0:LINE_DEPTH-1];
  // Write port
  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end
  // Registered read port
  always_ff @(posedge ref_clk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// >>> verilog/crd_readout.sv
// Purpose: Gain hold, binning and region cropping of the sensor pixel stream.
// Assumes: Pixels arrive in raster order, 1300 per line, sof on the first.
// Notes:   Settings are sampled on the first pixel of each frame.
`timescale 1ns/100ps
`default_nettype none
module crd_readout
  import crd_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [8:0]   gainCode,
  input  wire logic [2:0]   currentVideoFormat,
  input  wire logic [2:0]   currentVideoMode,
  input  wire crd_roi_t     regionOfInterest,
  input  wire logic         colorVariant,
  input  wire logic         inValid,
  input  wire crd_pix_in_t  inPix,
  output logic              inReady,
  output logic              outValid,
  output crd_pix_out_t      outPix,
  input  wire logic         outReady,
  output logic [8:0]        variableGainStage,
  output logic [15:0]       gainMilliDb,
  output logic [23:0]       frameCycles,
  output logic [2:0]        activeMode,
  output logic [10:0]       outWidth,
  output logic [10:0]       outHeight
);
  import crd_pkg::*;
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q; // Release shifter
  logic       rstN;      // Synchronised reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync_q <= 2'b00;
    end
    else
    begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];
  // ----------------------------------------------------------------
  // Settings taken at frame start
  // ----------------------------------------------------------------
  crd_mode_t   mode_q, newMode, effMode; // Latched, requested, in force
  crd_roi_t    roi_q, effRoi;            // Latched and in-force window
  logic        acc, frameStart;          // Accept strobe, first pixel
  assign acc        = inValid && inReady;
  assign frameStart = acc && inPix.sof;
  // Decode format and mode selectors
  always_comb
  begin
    newMode = MODE_NORMAL;
    if (currentVideoFormat == FORMAT_SCALABLE)
    begin
      case (currentVideoMode)
        SEL_ROI:  newMode = MODE_ROI;
        SEL_HBIN: newMode = colorVariant ? MODE_NORMAL : MODE_HBIN;
        SEL_VBIN: newMode = colorVariant ? MODE_NORMAL : MODE_VBIN;
        SEL_FBIN: newMode = colorVariant ? MODE_NORMAL : MODE_FBIN;
        default:  newMode = MODE_NORMAL;
      endcase
    end
  end
  assign effMode = frameStart ? newMode : mode_q;
  assign effRoi  = frameStart ? regionOfInterest : roi_q;
  // Shadow the settings only on the first pixel of a frame
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mode_q            <= MODE_NORMAL;
      roi_q             <= '0;
      variableGainStage <= GAIN_DEFAULT;
    end
    else if (frameStart)
    begin
      mode_q            <= newMode;
      roi_q             <= regionOfInterest;
      variableGainStage <= (gainCode > GAIN_TOP) ? GAIN_TOP : gainCode;
    end
  end
  // ----------------------------------------------------------------
  // Reported figures
  // ----------------------------------------------------------------
  logic [10:0] rows;       // Rows read this frame
  logic [10:0] skipped;    // Rows skipped out of the reference
  logic [31:0] ftSum;      // Frame time in cycles, full width
  logic [31:0] gainProd;   // Code times slope
  always_comb
  begin
    rows     = (mode_q == MODE_ROI) ? roi_q.height : SENSOR_ROWS;
    skipped  = (rows >= FT_ROW_REF) ? 11'h000 : FT_ROW_REF - rows;
    ftSum    = 32'(FT_FIXED_CYC) + 32'(skipped) * 32'(FT_SKIP_CYC)
             + (32'(rows) + 32'h1) * 32'(FT_ROW_CYC);
    gainProd = 32'(variableGainStage) * 32'(GAIN_SLOPE_Q8);
  end
  // Registered status outputs
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      gainMilliDb <= '0;
      frameCycles <= '0;
      activeMode  <= MODE_NORMAL;
      outWidth    <= SENSOR_COLS;
      outHeight   <= SENSOR_ROWS;
    end
    else
    begin
      gainMilliDb <= GAIN_BASE_MDB + gainProd[23:8];
      activeMode  <= mode_q;
      if (mode_q == MODE_VBIN || mode_q == MODE_FBIN)
        frameCycles <= 24'(FT_BIN_CYC);
      else
        frameCycles <= ftSum[23:0];
      case (mode_q)
        MODE_HBIN: begin outWidth <= BIN_COLS;     outHeight <= SENSOR_ROWS; end
        MODE_VBIN: begin outWidth <= SENSOR_COLS;  outHeight <= BIN_ROWS;    end
        MODE_FBIN: begin outWidth <= BIN_COLS;     outHeight <= BIN_ROWS;    end
        MODE_ROI:  begin outWidth <= roi_q.width;  outHeight <= roi_q.height; end
        default:   begin outWidth <= SENSOR_COLS;  outHeight <= SENSOR_ROWS; end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Position tracking and frame state
  // ----------------------------------------------------------------
  crd_state_t  state_q;          // Waiting for or inside a frame
  logic [10:0] col_q, row_q;     // Position of the next pixel
  logic [10:0] curCol, curRow;   // Position of the accepted pixel
  logic        inFrame, lastPix; // Pixel belongs to a frame, frame end
  assign curCol  = inPix.sof ? 11'h000 : col_q;
  assign curRow  = inPix.sof ? 11'h000 : row_q;
  assign inFrame = acc && (inPix.sof || state_q == ST_FRAME);
  assign lastPix = curCol == SENSOR_COLS - 11'h1 && curRow == SENSOR_ROWS - 11'h1;
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q <= ST_WAIT;
      col_q   <= '0;
      row_q   <= '0;
    end
    else if (inFrame)
    begin
      case (state_q)
        ST_WAIT:  state_q <= lastPix ? ST_WAIT : ST_FRAME;
        ST_FRAME: state_q <= lastPix ? ST_WAIT : ST_FRAME;
        default:  state_q <= ST_WAIT;
      endcase
      col_q <= (curCol == SENSOR_COLS - 11'h1) ? 11'h000 : curCol + 11'h1;
      row_q <= (curCol == SENSOR_COLS - 11'h1) ? curRow + 11'h1 : curRow;
    end
  end
  // ----------------------------------------------------------------
  // Stage A: crop and pair columns
  // ----------------------------------------------------------------
  logic             hMode, vMode, inRoi, produce;
  logic [11:0]      roiRight, roiBottom;
  logic [PIX_W-1:0] hold_q;                 // First sample of a column pair
  logic             aV_q, aSof_q, aEol_q, aWr_q, aAdd_q;
  logic [SUM_W-1:0] aVal_q;
  logic [10:0]      aIdx_q;
  assign hMode     = effMode == MODE_HBIN || effMode == MODE_FBIN;
  assign vMode     = effMode == MODE_VBIN || effMode == MODE_FBIN;
  assign roiRight  = {1'b0, effRoi.left} + {1'b0, effRoi.width};
  assign roiBottom = {1'b0, effRoi.top} + {1'b0, effRoi.height};
  assign inRoi = effMode != MODE_ROI
              || ({1'b0, curCol} >= {1'b0, effRoi.left} && {1'b0, curCol} < roiRight
               && {1'b0, curRow} >= {1'b0, effRoi.top} && {1'b0, curRow} < roiBottom);
  assign produce = inFrame && inRoi && !(hMode && !curCol[0]);
  // Hold even column while pairing
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      hold_q <= '0;
    else if (inFrame && hMode && !curCol[0])
      hold_q <= inPix.data;
  end
  // Build one line element per produced pixel or pair
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      aV_q <= 1'b0; aSof_q <= 1'b0; aEol_q <= 1'b0; aWr_q <= 1'b0; aAdd_q <= 1'b0;
      aVal_q <= '0; aIdx_q <= '0;
    end
    else
    begin
      aV_q  <= produce;
      aWr_q <= vMode && !curRow[0];
      aAdd_q <= vMode && curRow[0];
      if (hMode)
      begin
        aVal_q <= SUM_W'(hold_q) + SUM_W'(inPix.data);
        aIdx_q <= {1'b0, curCol[10:1]};
        aEol_q <= curCol == SENSOR_COLS - 11'h1;
      end
      else
      begin
        aVal_q <= SUM_W'(inPix.data);
        aIdx_q <= curCol;
        aEol_q <= (effMode == MODE_ROI) ? {1'b0, curCol} == roiRight - 12'h1
                                        : curCol == SENSOR_COLS - 11'h1;
      end
      if (effMode == MODE_ROI)
        aSof_q <= curCol == effRoi.left && curRow == effRoi.top;
      else
        // First element is column 1 when pairing columns, row 1 when pairing rows
        aSof_q <= curCol == {10'h000, hMode} && curRow == {10'h000, vMode};
    end
  end
  // ----------------------------------------------------------------
  // Stage B: pair rows through the line store
  // ----------------------------------------------------------------
  logic             bV_q, bSof_q, bEol_q, bAdd_q;
  logic [SUM_W-1:0] bVal_q, lineData;
  logic [10:0]      bIdx_q;
  crd_line_mem uLineMem (
    .ref_clk (ref_clk),
    .wrEn    (aV_q && aWr_q),
    .wrAddr  (aIdx_q),
    .wrData  (aVal_q),
    .rdAddr  (aIdx_q),
    .rdData  (lineData)
  );
  // Even rows park in the store, odd rows go on
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      bV_q <= 1'b0; bSof_q <= 1'b0; bEol_q <= 1'b0; bAdd_q <= 1'b0;
      bVal_q <= '0; bIdx_q <= '0;
    end
    else
    begin
      bV_q   <= aV_q && !aWr_q;
      bSof_q <= aSof_q;
      bEol_q <= aEol_q;
      bAdd_q <= aAdd_q;
      bVal_q <= aVal_q;
      bIdx_q <= aIdx_q;
    end
  end
  // ----------------------------------------------------------------
  // Two-entry output buffer and reservation
  // ----------------------------------------------------------------
  crd_pix_out_t pushPix, slot1_q;
  logic [1:0]   cnt_q, res_q, resNext;
  logic         pop, push;
  assign push         = bV_q;
  assign pop          = outValid && outReady;
  // Odd row element adds its parked partner from the line store
  assign pushPix = '{sof: bSof_q, eol: bEol_q,
                     data: bVal_q + (bAdd_q ? lineData : '0)};
  // Every producing pixel books a slot until popped or parked
  assign resNext = res_q + {1'b0, produce} - {1'b0, pop} - {1'b0, aV_q && aWr_q};
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      res_q   <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      res_q   <= resNext;
      inReady <= resNext < 2'd2;
    end
  end
  // Head slot drives the outputs directly
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cnt_q <= '0; outValid <= 1'b0; outPix <= '0; slot1_q <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (cnt_q == 2'd0) outPix <= pushPix;
          else slot1_q <= pushPix;
          cnt_q <= cnt_q + 2'd1;
          outValid <= 1'b1;
        end
        2'b01:
        begin
          outPix <= slot1_q;
          cnt_q <= cnt_q - 2'd1;
          outValid <= cnt_q == 2'd2;
        end
        2'b11:
        begin
          outPix <= (cnt_q == 2'd2) ? slot1_q : pushPix;
          if (cnt_q == 2'd2) slot1_q <= pushPix;
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);
  chk_gain_clamp: assert property (variableGainStage <= GAIN_TOP)
    else $error("gain code above effective range");
  chk_gain_db_top: assert property (
    variableGainStage == GAIN_TOP |=> gainMilliDb == 16'd34499)
    else $error("top gain code not at 34.5 dB");
  chk_gain_default: assert property ($rose(rstN) |-> variableGainStage == GAIN_DEFAULT)
    else $error("gain not default after reset");
  chk_hbin_width: assert property (
    push && pushPix.eol && activeMode == MODE_HBIN |-> bIdx_q == 11'd649)
    else $error("horizontal pair line not 650 wide");
  chk_vbin_pairs: assert property (push && mode_q == MODE_VBIN |-> bAdd_q)
    else $error("vertical binning sent an unpaired row");
  chk_fbin_pairs: assert property (
    push && mode_q == MODE_FBIN |-> bAdd_q && bIdx_q < 11'd650)
    else $error("full binning element out of range");
  chk_mode_select: assert property (frameStart && currentVideoFormat == FORMAT_SCALABLE
      && currentVideoMode == SEL_VBIN && !colorVariant |=> mode_q == MODE_VBIN)
    else $error("vertical binning not selected");
  chk_roi_select: assert property (frameStart && currentVideoFormat == FORMAT_SCALABLE
      && currentVideoMode == SEL_ROI |=> mode_q == MODE_ROI)
    else $error("region mode not selected");
  chk_color_nobin: assert property (
    frameStart && colorVariant |=> mode_q inside {MODE_NORMAL, MODE_ROI})
    else $error("binning on colour variant");
  chk_roi_inside: assert property (aV_q && mode_q == MODE_ROI |-> aIdx_q >= roi_q.left
      && {1'b0, aIdx_q} < {1'b0, roi_q.left} + {1'b0, roi_q.width})
    else $error("pixel outside region sent");
  chk_frame_time: assert property (
    mode_q == MODE_VBIN ##1 mode_q == MODE_VBIN |-> frameCycles == 24'd8737440)
    else $error("binned frame time wrong");
  chk_shadow_hold: assert property (!frameStart |=> $stable(mode_q) && $stable(roi_q))
    else $error("settings changed mid frame");
  chk_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outPix))
    else $error("stalled word lost");
  cov_hbin: cover property (push && mode_q == MODE_HBIN);
  cov_fbin: cover property (push && mode_q == MODE_FBIN);
  cov_roi: cover property (push && mode_q == MODE_ROI);
  cov_stall: cover property ((outValid && !outReady) [*3]);
endmodule
`default_nettype wire

// >>> test/crd_sensor_model.sv
// Purpose: Sensor side pixel source that feeds the readout block in raster order.
// Assumes: Pixel value is column plus row, low 8 bits; 1300 pixels per row.
// Notes:   Idle data shows the inverse of the value on offer, never a stale copy.
`timescale 1ns/100ps
`default_nettype none
module crd_sensor_model
  import crd_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  run,
  input  wire logic  slow,
  input  wire logic  inReady,
  output logic       inValid,
  output crd_pix_in_t inPix
);
  logic [10:0] col;  // Column of the pixel on offer
  logic [10:0] row;  // Row of the pixel on offer
  logic        took; // Pixel accepted at the last rising edge
  logic [7:0]  val;  // Sample value of the pixel on offer
  // Position and valid settle at the first falling edge, while run is low
  // Record an accept at the sampling edge
  always @(posedge ref_clk) took <= inValid && inReady;
  // ------------------------------------------------------------
  // Offer pixels, hold each one until it is taken
  // ------------------------------------------------------------
  always @(negedge ref_clk)
  begin
    if (!run)
    begin
      col <= 11'h000;
      row <= 11'h000;
      inValid <= 1'b0;
    end
    else if (took)
    begin
      // Next raster position; slow mode leaves a gap after each pixel
      col <= (col == 11'h513) ? 11'h000 : col + 11'h001;
      row <= (col == 11'h513) ? row + 11'h001 : row;
      inValid <= !slow;
    end
    else
      inValid <= 1'b1;
  end
  // Frame start marks column 0, row 0
  assign val   = col[7:0] + row[7:0];
  assign inPix = '{sof: (col == 11'h000) && (row == 11'h000), data: inValid ? val : ~val};
endmodule
`default_nettype wire

// >>> test/crd_readout_gain_binning_roi_tb_top.sv
// Purpose: Self-checking bench for gain hold, binning and region cropping.
// Assumes: Settings are applied before each frame start; short partial frames.
// Notes:   Each case aborts the previous frame and checks its first eight words.
`timescale 1ns/100ps
`default_nettype none
module crd_readout_gain_binning_roi_tb_top;
  import crd_pkg::*;
  // ------------------------------------------------------------
  // Case table
  // ------------------------------------------------------------
  typedef struct {
    logic [2:0] fmt, mode; logic color; logic [8:0] gain; crd_roi_t roi;
    logic [2:0] eMode; logic [10:0] eW, eH; logic [23:0] eFc; logic [8:0] eGain;
    logic [15:0] eMdb; int mul, off, eolAt;
  } crd_case_t;
  // Regions stay inside the array and above the minimum area
  // Gain codes stay at or below 319, save one deliberate clamp probe
  crd_case_t cases [7] = '{
    '{3'h7, 3'h1, 1'b0, 9'h000, '0, 3'h2, 11'h28a, 11'h406, 24'hfbff72, 9'h000, 16'h1194,
      32'h4, 32'h1, 32'h8},
    '{3'h7, 3'h2, 1'b0, 9'h065, '0, 3'h3, 11'h514, 11'h203, 24'h8552a0, 9'h065, 16'h36ae,
      32'h2, 32'h1, 32'h8},
    '{3'h7, 3'h3, 1'b0, 9'h13f, '0, 3'h4, 11'h28a, 11'h203, 24'h8552a0, 9'h13f, 16'h86c3,
      32'h8, 32'h4, 32'h8},
    '{3'h7, 3'h0, 1'b0, 9'h190, '{11'h003, 11'h001, 11'h008, 11'h300}, 3'h1, 11'h008,
      11'h300, 24'hc05376, 9'h13f, 16'h86c3, 32'h1, 32'h4, 32'h7},
    '{3'h7, 3'h0, 1'b0, 9'h065, '{11'h000, 11'h000, 11'h514, 11'h406}, 3'h1, 11'h514,
      11'h406, 24'hfbff72, 9'h065, 16'h36ae, 32'h1, 32'h0, 32'h8},
    '{3'h7, 3'h1, 1'b1, 9'h065, '0, 3'h0, 11'h514, 11'h406, 24'hfbff72, 9'h065, 16'h36ae,
      32'h1, 32'h0, 32'h8},
    '{3'h0, 3'h2, 1'b0, 9'h065, '0, 3'h0, 11'h514, 11'h406, 24'hfbff72, 9'h065, 16'h36ae,
      32'h1, 32'h0, 32'h8}};
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         ref_clk = 1'b0;  // 200 MHz clock
  logic         reset_n;         // Active low reset
  logic [8:0]   gainCode;        // Requested gain
  logic [2:0]   currentVideoFormat, currentVideoMode;
  crd_roi_t     regionOfInterest; // Crop window
  logic         colorVariant, inValid, inReady, outValid, outReady, run, slow, stallOut;
  crd_pix_in_t  inPix;           // Sensor sample
  crd_pix_out_t outPix;          // Output word
  logic [8:0]   variableGainStage;
  logic [15:0]  gainMilliDb;
  logic [23:0]  frameCycles;
  logic [2:0]   activeMode;
  logic [10:0]  outWidth, outHeight;
  crd_pix_out_t got [$];         // Words taken from the block
  crd_case_t    c;               // Case in progress
  int           nMismatch = 0;
  int           samplesChecked = 0;
  always #2.5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Design and sensor source
  // ------------------------------------------------------------
  crd_readout crd_readout_i (.ref_clk(ref_clk), .reset_n(reset_n), .gainCode(gainCode),
    .currentVideoFormat(currentVideoFormat), .currentVideoMode(currentVideoMode),
    .regionOfInterest(regionOfInterest), .colorVariant(colorVariant), .inValid(inValid),
    .inPix(inPix), .inReady(inReady), .outValid(outValid), .outPix(outPix),
    .outReady(outReady), .variableGainStage(variableGainStage), .gainMilliDb(gainMilliDb),
    .frameCycles(frameCycles), .activeMode(activeMode), .outWidth(outWidth),
    .outHeight(outHeight));
  crd_sensor_model crd_sensor_model_i (.ref_clk(ref_clk), .run(run), .slow(slow),
    .inReady(inReady), .inValid(inValid), .inPix(inPix));
  // Receiver takes words, stalling every other cycle when asked
  always @(posedge ref_clk) if (outValid && outReady) got.push_back(outPix);
  // First falling edge brings it up, since stallOut starts low
  always @(negedge ref_clk) outReady <= !(stallOut && outReady);
  // ------------------------------------------------------------
  // Compare and finish
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #450000;
    nMismatch++;
    stop_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0; run = 1'b0; slow = 1'b0; stallOut = 1'b0;
    gainCode = 9'h065; currentVideoFormat = 3'h0; currentVideoMode = 3'h0;
    regionOfInterest = '0; colorVariant = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("resetGain", 32'(variableGainStage), 32'h65);
    for (int i = 0; i < 7; i++)
    begin
      // Abort the previous frame and let the buffer drain
      run = 1'b0;
      repeat (20) @(negedge ref_clk);
      got.delete();
      c = cases[i];
      currentVideoFormat = c.fmt; currentVideoMode = c.mode; colorVariant = c.color;
      gainCode = c.gain; regionOfInterest = c.roi; slow = i[0]; stallOut = i[1];
      run = 1'b1;
      for (int w = 0; w < 20000 && got.size() < 8; w++) @(negedge ref_clk);
      check("words", 32'(got.size() >= 8), 32'h1);
      for (int k = 0; k < 8 && k < got.size(); k++)
      begin
        check("data", 32'(got[k].data), c.mul * k + c.off);
        check("sof", 32'(got[k].sof), 32'(k == 0));
        check("eol", 32'(got[k].eol), 32'(k == c.eolAt));
      end
      check("mode", 32'(activeMode), 32'(c.eMode));
      check("width", 32'(outWidth), 32'(c.eW));
      check("height", 32'(outHeight), 32'(c.eH));
      check("frameCycles", 32'(frameCycles), 32'(c.eFc));
      check("gainCode", 32'(variableGainStage), 32'(c.eGain));
      check("gainMdb", 32'(gainMilliDb), 32'(c.eMdb));
      // Changes mid frame must not reach the status outputs; the wait also
      // lets a whole column-paired line reach its last word
      currentVideoMode = 3'h5; gainCode = 9'h000;
      repeat (2000) @(negedge ref_clk);
      check("midMode", 32'(activeMode), 32'(c.eMode));
      check("midGain", 32'(variableGainStage), 32'(c.eGain));
    end
    stop_test();
  end
endmodule
`default_nettype wire
